// ---- rtl/swsc_pkg.sv ----
package swsc_pkg;
	// ==========================================
	// Control word layout
	// ==========================================
	localparam int CTRL_W = 6;
	localparam int STROBE_W = 5;
	localparam int STROBE_LSB = 1;
	localparam int STROBE_MSB = 5;
	localparam int TEST_BIT = 0;
	localparam int SIGN_BIT = 4;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
	// Strobe step in tenths of a percent of the VCO period
	localparam logic signed [5:0] STROBE_STEP_TPCT = 6'sh12;
	localparam int SHIFT_W = 10;
	// ==========================================
	// Range select and code types
	// ==========================================
	typedef enum logic [2:0] {
		RNG_1M25, RNG_2M5, RNG_5M, RNG_10M, RNG_20M, RNG_50M
	} swsc_range_t;
	localparam logic [2:0] RSEL_1M25 = 3'h6;
	localparam logic [2:0] RSEL_2M5 = 3'h5;
	localparam logic [2:0] RSEL_5M = 3'h4;
	localparam logic [2:0] RSEL_10M = 3'h3;
	localparam logic [2:0] RSEL_20M = 3'h2;
	localparam logic [2:0] RSEL_50M = 3'h0;
	localparam logic [15:0] TOP_1M25_KHZ = 16'h04e2;
	localparam logic [15:0] TOP_2M5_KHZ = 16'h09c4;
	localparam logic [15:0] TOP_5M_KHZ = 16'h1388;
	localparam logic [15:0] TOP_10M_KHZ = 16'h2710;
	localparam logic [15:0] TOP_20M_KHZ = 16'h4e20;
	localparam logic [15:0] ONE_N_MAX_KHZ = 16'h9470;
	localparam logic [2:0] MIN_N_GCR = 3'h1;
	localparam logic [2:0] MIN_N_ONE_N = 3'h2;
	// ==========================================
	// Host register map (word index)
	// ==========================================
	localparam int AV_ADDR_W = 2;
	localparam logic [1:0] REG_CMD = 2'h0;
	localparam logic [1:0] REG_STATUS = 2'h1;
	localparam logic [1:0] REG_CODE = 2'h2;
	localparam logic [1:0] REG_ALIGN = 2'h3;
	localparam int CMD_CENTRE_BIT = 8;
	localparam int CODE_MIN_N_LSB = 0;
	localparam int CODE_RSEL_LSB = 4;
	localparam int CODE_KHZ_LSB = 16;
	localparam int ALIGN_EARLY_LSB = 0;
	localparam int ALIGN_LATE_LSB = 8;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_GCR_BAD_BIT = 1;
	localparam int ST_FREQ_BAD_BIT = 2;
	localparam int ST_SUGG_LSB = 4;
	localparam int ST_WORD_LSB = 8;
	// ==========================================
	// Serial timing
	// ==========================================
	localparam int CLK_PERIOD_PS = 5000;
	localparam int SCLK_HALF_NS = 500;
	localparam int SCLK_HALF_CYC =
		(SCLK_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	typedef enum logic [2:0] {
		ST_IDLE, ST_SETUP, ST_HIGH, ST_DONE, ST_GAP
	} swsc_state_t;
	// Sign-magnitude strobe field to signed step count
	function automatic logic signed [5:0] swsc_sm2s(
		input logic [STROBE_W-1:0] sm);
		logic signed [5:0] mag;
		mag = signed'({2'h0, sm[3:0]});
		return sm[SIGN_BIT] ? mag : -mag;
	endfunction
	function automatic logic [STROBE_W-1:0] swsc_s2sm(
		input logic signed [5:0] v);
		logic signed [5:0] a;
		a = (v < 0) ? -v : v;
		return {(v >= 0), a[3:0]};
	endfunction
endpackage

// ---- rtl/swsc_if.sv ----
`timescale 1ns/1ps
interface swsc_if;
	logic cfg_serial_data;
	logic cfg_serial_clk;
	logic cfg_load_enable_n;
	modport dev (
		input cfg_serial_data,
		input cfg_serial_clk,
		input cfg_load_enable_n
	);
	modport host (
		output cfg_serial_data,
		output cfg_serial_clk,
		output cfg_load_enable_n
	);
endinterface

// ---- rtl/swsc_dev.sv ----
`timescale 1ns/1ps
module swsc_dev
	import swsc_pkg::*;
(
	input wire logic CLK_IN,
	input wire logic RST_IN,
	swsc_if.dev CFG,
	input wire logic VCO_RANGE_SEL_HI_IN,
	input wire logic VCO_RANGE_SEL_MID_IN,
	input wire logic VCO_RANGE_SEL_LO_IN,
	input wire logic GAIN_BOOST_DISABLE_IN,
	input wire logic VCO_TICK_IN,
	output logic signed [5:0] STROBE_WORD_OUT,
	output logic signed [SHIFT_W-1:0] WINDOW_SHIFT_OUT,
	output logic TEST_MODE_OUT,
	output logic VCO_RUN_OUT,
	output logic DIV_CLK_OUT,
	output swsc_range_t RANGE_OUT,
	output logic GCR_ALLOWED_OUT,
	output logic ONE_N_CAPPED_OUT
);
	// ==========================================
	// Pin synchronisers
	// ==========================================
	localparam int NPIN = 8;
	logic [NPIN-1:0] pins;
	logic [NPIN-1:0] s1_reg;
	logic [NPIN-1:0] s2_reg;
	logic [NPIN-1:0] s2_next;
	logic sdat, sclk, sen_n, gbd, vco;
	logic [2:0] rsel;
	assign pins = {VCO_TICK_IN, GAIN_BOOST_DISABLE_IN,
		VCO_RANGE_SEL_HI_IN, VCO_RANGE_SEL_MID_IN, VCO_RANGE_SEL_LO_IN,
		CFG.cfg_load_enable_n, CFG.cfg_serial_clk, CFG.cfg_serial_data};
	always_comb
	begin
		s2_next = s1_reg;
	end
	always_ff @(posedge CLK_IN)
	begin
		s1_reg <= pins;
		s2_reg <= s2_next;
	end
	assign sdat = s2_reg[0];
	assign sclk = s2_reg[1];
	assign sen_n = s2_reg[2];
	assign rsel = s2_reg[5:3];
	assign gbd = s2_reg[6];
	assign vco = s2_reg[7];
	// ==========================================
	// Serial control register
	// ==========================================
	logic sclk_q_reg, sclk_q_next, en_q_reg, en_q_next;
	logic [CTRL_W-1:0] shift_reg, shift_next;
	logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
	always_comb
	begin
		sclk_q_next = sclk;
		en_q_next = sen_n;
		shift_next = shift_reg;
		ctrl_next = ctrl_reg;
		// Clock and data count only while enable is low
		if (!sen_n && sclk && !sclk_q_reg) // R01 R02
			shift_next = {shift_reg[CTRL_W-2:0], sdat}; // R15
		// Commit on enable release, so a partial load never shows
		if (sen_n && !en_q_reg)
			ctrl_next = shift_reg; // R15
	end
	always_ff @(posedge CLK_IN)
	begin
		if (RST_IN)
		begin
			sclk_q_reg <= 1'b0;
			en_q_reg <= 1'b1;
			shift_reg <= CTRL_RESET;
			ctrl_reg <= CTRL_RESET;
		end
		else
		begin
			sclk_q_reg <= sclk_q_next;
			en_q_reg <= en_q_next;
			shift_reg <= shift_next;
			ctrl_reg <= ctrl_next;
		end
	end
	// ==========================================
	// Decode outputs
	// ==========================================
	logic signed [5:0] word_next;
	logic signed [SHIFT_W-1:0] shft_next;
	swsc_range_t rng_next;
	logic test_next, div_next, gcr_next, cap_next;
	always_comb
	begin
		word_next = swsc_sm2s(ctrl_reg[STROBE_MSB:STROBE_LSB]); // R05
		// 15 steps of 1.8 % each way, so +-27.0 % at the extremes
		shft_next = SHIFT_W'(word_next * STROBE_STEP_TPCT); // R03 R04
		test_next = ctrl_reg[TEST_BIT]; // R13
		div_next = test_next ? gbd : vco; // R13
		casez (rsel) // R06
			3'b11?: rng_next = RNG_1M25;
			3'b101: rng_next = RNG_2M5;
			3'b100: rng_next = RNG_5M;
			3'b011: rng_next = RNG_10M;
			3'b010: rng_next = RNG_20M;
			default: rng_next = RNG_50M;
		endcase
		gcr_next = (rng_next != RNG_20M) && (rng_next != RNG_50M);
		cap_next = (rng_next == RNG_50M);
	end
	always_ff @(posedge CLK_IN)
	begin
		if (RST_IN)
		begin
			STROBE_WORD_OUT <= 6'sh00;
			WINDOW_SHIFT_OUT <= '0;
			TEST_MODE_OUT <= 1'b0;
			VCO_RUN_OUT <= 1'b1;
			DIV_CLK_OUT <= 1'b0;
			RANGE_OUT <= RNG_50M;
			GCR_ALLOWED_OUT <= 1'b0;
			ONE_N_CAPPED_OUT <= 1'b1;
		end
		else
		begin
			STROBE_WORD_OUT <= word_next;
			WINDOW_SHIFT_OUT <= shft_next;
			TEST_MODE_OUT <= test_next;
			VCO_RUN_OUT <= !test_next; // R13
			DIV_CLK_OUT <= div_next;
			RANGE_OUT <= rng_next;
			GCR_ALLOWED_OUT <= gcr_next;
			ONE_N_CAPPED_OUT <= cap_next;
		end
	end
endmodule

// ---- rtl/swsc_host.sv ----
// Added by the designer: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
// Behaviour
// R01 - Enable low: clock one bit per pulse
// R02 - Enable high: device ignores data and clock
// R03 - Window shift is M times 1.8 percent
// R04 - Shift spans about 27 percent either way
// R05 - Strobe field is sign-magnitude, both zeros
// R06 - Three range pins pick VCO sub-range
// R07 - No GCR in top two ranges
// R08 - 1,N codes capped at 38 MHz
// R09 - Prefer range near its upper boundary
// R10 - Control register must always be loaded
// R11 - Offsets suit margin tests and retries
// R12 - Centre window on mean of limits
// R13 - Final bit selects test mode
// R14 - All zeros gives nominal, no test
// R15 - MSB first, rising clock, commit on release
module swsc_host
	import swsc_pkg::*;
#(
	parameter int HALF_CYC = SCLK_HALF_CYC
)
(
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic [AV_ADDR_W-1:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	output logic [31:0] AVS_READDATA_OUT,
	output logic AVS_WAITREQUEST_OUT,
	swsc_if.host CFG
);
	localparam int CNT_W = $clog2(HALF_CYC + 1);
	localparam int BIT_W = $clog2(CTRL_W);
	localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(HALF_CYC - 1);
	localparam logic [BIT_W-1:0] BIT_TOP = BIT_W'(CTRL_W - 1);
	// ==========================================
	// Software registers
	// ==========================================
	logic [CTRL_W-1:0] word_reg, word_next;
	logic [CTRL_W-1:0] last_reg, last_next;
	logic pend_reg, pend_next;
	logic [31:0] code_reg, code_next;
	logic [15:0] align_reg, align_next;
	logic [31:0] rdata_reg, rdata_next;
	logic rdone_reg, rdone_next;
	logic busy, wr_cmd, gcr_bad, freq_bad;
	logic [2:0] min_n, rsel, sugg;
	logic [15:0] khz;
	logic signed [6:0] sum;
	logic [STROBE_W-1:0] centre;
	swsc_state_t st_reg, st_next;
	assign busy = pend_reg || (st_reg != ST_IDLE);
	assign wr_cmd = AVS_WRITE_IN && (AVS_ADDRESS_IN == REG_CMD);
	// Stall a command write until the previous load has gone out
	assign AVS_WAITREQUEST_OUT = (AVS_READ_IN && !rdone_reg)
		|| (wr_cmd && busy);
	assign min_n = code_reg[CODE_MIN_N_LSB +: 3];
	assign rsel = code_reg[CODE_RSEL_LSB +: 3];
	assign khz = code_reg[CODE_KHZ_LSB +: 16];
	assign gcr_bad = (min_n == MIN_N_GCR)
		&& (rsel == RSEL_20M || rsel[2:1] == RSEL_50M[2:1]); // R07
	assign freq_bad = (min_n == MIN_N_ONE_N)
		&& (rsel[2:1] == RSEL_50M[2:1]) && (khz > ONE_N_MAX_KHZ); // R08
	always_comb
	begin
		// Smallest range that still holds the rate sits near its top
		if (khz <= TOP_1M25_KHZ) // R09
			sugg = RSEL_1M25;
		else if (khz <= TOP_2M5_KHZ)
			sugg = RSEL_2M5;
		else if (khz <= TOP_5M_KHZ)
			sugg = RSEL_5M;
		else if (khz <= TOP_10M_KHZ)
			sugg = RSEL_10M;
		else if (khz <= TOP_20M_KHZ)
			sugg = RSEL_20M;
		else
			sugg = RSEL_50M;
		// Floor of the mean, so within half a step of centre
		sum = 7'(swsc_sm2s(align_reg[ALIGN_EARLY_LSB +: STROBE_W]))
			+ 7'(swsc_sm2s(align_reg[ALIGN_LATE_LSB +: STROBE_W]));
		centre = swsc_s2sm(6'(sum >>> 1)); // R12
	end
	always_comb
	begin
		word_next = word_reg;
		pend_next = pend_reg;
		code_next = code_reg;
		align_next = align_reg;
		rdata_next = rdata_reg;
		rdone_next = AVS_READ_IN && !rdone_reg;
		if (st_reg == ST_SETUP && !pend_reg)
			pend_next = 1'b0;
		if (pend_reg && st_reg == ST_IDLE)
			pend_next = 1'b0;
		if (wr_cmd && !busy)
		begin
			pend_next = 1'b1;
			if (AVS_WRITEDATA_IN[CMD_CENTRE_BIT])
				word_next = {centre, 1'b0};
			else
				word_next = AVS_WRITEDATA_IN[CTRL_W-1:0];
		end
		if (AVS_WRITE_IN && AVS_ADDRESS_IN == REG_CODE)
			code_next = AVS_WRITEDATA_IN;
		if (AVS_WRITE_IN && AVS_ADDRESS_IN == REG_ALIGN)
			align_next = AVS_WRITEDATA_IN[15:0];
		if (AVS_READ_IN && !rdone_reg)
		begin
			rdata_next = '0;
			case (AVS_ADDRESS_IN)
				REG_CMD: rdata_next[CTRL_W-1:0] = word_reg;
				REG_STATUS:
				begin
					rdata_next[ST_BUSY_BIT] = busy;
					rdata_next[ST_GCR_BAD_BIT] = gcr_bad;
					rdata_next[ST_FREQ_BAD_BIT] = freq_bad;
					rdata_next[ST_SUGG_LSB +: 3] = sugg;
					rdata_next[ST_WORD_LSB +: CTRL_W] = last_reg;
				end
				REG_CODE: rdata_next = code_reg;
				default: rdata_next[15:0] = align_reg;
			endcase
		end
	end
	always_ff @(posedge CLK_IN)
	begin
		if (RST_IN)
		begin
			// A zero load follows every reset
			word_reg <= CTRL_RESET; // R10 R14
			pend_reg <= 1'b1; // R10
			code_reg <= '0;
			align_reg <= '0;
			rdata_reg <= '0;
			rdone_reg <= 1'b0;
		end
		else
		begin
			word_reg <= word_next;
			pend_reg <= pend_next;
			code_reg <= code_next;
			align_reg <= align_next;
			rdata_reg <= rdata_next;
			rdone_reg <= rdone_next;
		end
	end
	assign AVS_READDATA_OUT = rdata_reg;
	// ==========================================
	// Serial shifter
	// ==========================================
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic [BIT_W-1:0] bit_reg, bit_next;
	logic [CTRL_W-1:0] tx_reg, tx_next;
	logic sd_reg, sd_next, sc_reg, sc_next, en_reg, en_next;
	always_comb
	begin
		st_next = st_reg;
		cnt_next = (cnt_reg == '0) ? CNT_LOAD : cnt_reg - 1'b1;
		bit_next = bit_reg;
		tx_next = tx_reg;
		sd_next = sd_reg;
		sc_next = sc_reg;
		en_next = en_reg;
		last_next = last_reg;
		case (st_reg)
			ST_IDLE:
			begin
				cnt_next = CNT_LOAD;
				if (pend_reg)
				begin
					tx_next = word_reg;
					bit_next = BIT_TOP;
					en_next = 1'b0; // R01
					sd_next = word_reg[CTRL_W-1]; // R15
					st_next = ST_SETUP;
				end
			end
			ST_SETUP:
				if (cnt_reg == '0)
				begin
					sc_next = 1'b1; // R01 R15
					st_next = ST_HIGH;
				end
			ST_HIGH:
				if (cnt_reg == '0)
				begin
					sc_next = 1'b0;
					if (bit_reg == '0)
						st_next = ST_DONE;
					else
					begin
						bit_next = bit_reg - 1'b1;
						sd_next = tx_reg[bit_reg - 1'b1];
						st_next = ST_SETUP;
					end
				end
			ST_DONE:
				if (cnt_reg == '0)
				begin
					en_next = 1'b1; // R15
					last_next = tx_reg;
					st_next = ST_GAP;
				end
			ST_GAP:
				// Enable stays high a half period so the release is seen
				if (cnt_reg == '0) // R02
					st_next = ST_IDLE;
			default:
				st_next = ST_IDLE;
		endcase
	end
	always_ff @(posedge CLK_IN)
	begin
		if (RST_IN)
		begin
			st_reg <= ST_IDLE;
			cnt_reg <= '0;
			bit_reg <= '0;
			tx_reg <= CTRL_RESET;
			last_reg <= CTRL_RESET;
			sd_reg <= 1'b0;
			sc_reg <= 1'b0;
			en_reg <= 1'b1;
		end
		else
		begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			bit_reg <= bit_next;
			tx_reg <= tx_next;
			last_reg <= last_next;
			sd_reg <= sd_next;
			sc_reg <= sc_next;
			en_reg <= en_next;
		end
	end
	assign CFG.cfg_serial_data = sd_reg;
	assign CFG.cfg_serial_clk = sc_reg;
	assign CFG.cfg_load_enable_n = en_reg;
endmodule

// ---- bench/swsc_sva.sv ----
`timescale 1ns/1ps
module swsc_sva
	import swsc_pkg::*;
#(
	parameter int HALF = 2
)
(
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic cfg_serial_data,
	input wire logic cfg_serial_clk,
	input wire logic cfg_load_enable_n
);
	// ==========================================
	// Helper counters
	// ==========================================
	int hi_reg;
	int hi_next;
	int bit_reg;
	int bit_next;
	always_comb
	begin
		hi_next = (RST_IN || !cfg_serial_clk) ? 0 : hi_reg + 1;
		bit_next = (RST_IN || cfg_load_enable_n) ? 0 :
			bit_reg + ((cfg_serial_clk && hi_reg == 0) ? 1 : 0);
	end
	always_ff @(posedge CLK_IN)
	begin
		hi_reg <= hi_next;
		bit_reg <= bit_next;
	end
	// ==========================================
	// Wire rules
	// ==========================================
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);
	idle_clk_still_a: assert property (cfg_load_enable_n |-> !cfg_serial_clk)
		else $error("serial clock high outside frame");
	clk_half_a: assert property ($fell(cfg_serial_clk) |-> hi_reg == HALF)
		else $error("serial clock high time wrong");
	data_hold_a: assert property (cfg_serial_clk && $past(cfg_serial_clk)
		|-> $stable(cfg_serial_data)) else $error("data moved while clock high");
	frame_bits_a: assert property ($rose(cfg_load_enable_n)
		|-> bit_reg == CTRL_W) else $error("frame bit count wrong");
	lead_low_a: assert property ($fell(cfg_load_enable_n)
		|-> !cfg_serial_clk [*2]) else $error("clock rose too soon");
	tail_low_a: assert property ($rose(cfg_load_enable_n)
		|-> !$past(cfg_serial_clk, 1) && !$past(cfg_serial_clk, 2))
		else $error("enable released too soon");
	gap_hold_a: assert property ($rose(cfg_load_enable_n)
		|-> cfg_load_enable_n [*2]) else $error("frame gap too short");
	frame_len_a: assert property ($fell(cfg_load_enable_n)
		|-> !cfg_load_enable_n [*8] ##[1:30] cfg_load_enable_n)
		else $error("frame length wrong");
endmodule

// ---- bench/sync_window_strobe_config_bench.sv ----
`timescale 1ns/1ps
module sync_window_strobe_config_bench;
	import swsc_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] adr = 2'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdat;
	logic wreq;
	logic [2:0] rs = 3'h0;
	logic gain = 1'b0;
	logic tick = 1'b0;
	logic signed [5:0] m1;
	logic signed [5:0] m2;
	logic signed [9:0] sh;
	logic tst;
	logic run;
	logic div;
	swsc_range_t rng;
	logic gcr;
	logic cap;
	int bad_count = 0;
	int tests_run = 0;
	int cyc = 0;
	logic [31:0] s;
	swsc_if lnk();
	swsc_if rog();
	swsc_host #(.HALF_CYC(2)) swsc_host_i (.CLK_IN(clk), .RST_IN(rst),
		.AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
		.AVS_WRITEDATA_IN(wd), .AVS_READDATA_OUT(rdat),
		.AVS_WAITREQUEST_OUT(wreq), .CFG(lnk.host));
	swsc_dev swsc_dev_i (.CLK_IN(clk), .RST_IN(rst), .CFG(lnk.dev),
		.VCO_RANGE_SEL_HI_IN(rs[2]), .VCO_RANGE_SEL_MID_IN(rs[1]),
		.VCO_RANGE_SEL_LO_IN(rs[0]), .GAIN_BOOST_DISABLE_IN(gain),
		.VCO_TICK_IN(tick), .STROBE_WORD_OUT(m1), .WINDOW_SHIFT_OUT(sh),
		.TEST_MODE_OUT(tst), .VCO_RUN_OUT(run), .DIV_CLK_OUT(div),
		.RANGE_OUT(rng), .GCR_ALLOWED_OUT(gcr), .ONE_N_CAPPED_OUT(cap));
	// Second device fed by the bench so traffic outside a frame can be sent
	swsc_dev swsc_dev_i2 (.CLK_IN(clk), .RST_IN(rst), .CFG(rog.dev),
		.VCO_RANGE_SEL_HI_IN(rs[2]), .VCO_RANGE_SEL_MID_IN(rs[1]),
		.VCO_RANGE_SEL_LO_IN(rs[0]), .GAIN_BOOST_DISABLE_IN(gain),
		.VCO_TICK_IN(tick), .STROBE_WORD_OUT(m2), .WINDOW_SHIFT_OUT(),
		.TEST_MODE_OUT(), .VCO_RUN_OUT(), .DIV_CLK_OUT(), .RANGE_OUT(),
		.GCR_ALLOWED_OUT(), .ONE_N_CAPPED_OUT());
	swsc_sva #(.HALF(2)) swsc_sva_i (.CLK_IN(clk), .RST_IN(rst),
		.cfg_serial_data(lnk.cfg_serial_data),
		.cfg_serial_clk(lnk.cfg_serial_clk),
		.cfg_load_enable_n(lnk.cfg_load_enable_n));
	initial forever #2.5 clk = ~clk;
	initial
	begin
		rog.cfg_load_enable_n <= 1'b1;
		rog.cfg_serial_clk <= 1'b0;
		rog.cfg_serial_data <= 1'b0;
	end
	// ==========================================
	// Tasks
	// ==========================================
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic av(input logic w, input logic [1:0] a, input logic [31:0] d);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		do @(posedge clk); while (wreq !== 1'b0);
		s = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	endtask
	// Status shows the word once the frame has gone; then allow sync delay
	task automatic sent(input logic [5:0] w);
		do av(1'b0, REG_STATUS, 32'h0);
		while (s[0] !== 1'b0 || s[13:8] !== w);
		repeat (8) @(posedge clk);
	endtask
	task automatic rg(input logic [5:0] w, input logic en);
		for (int i = 5; i >= 0; i--)
		begin
			rog.cfg_load_enable_n <= en;
			rog.cfg_serial_data <= w[i];
			repeat (2) @(posedge clk);
			rog.cfg_serial_clk <= 1'b1;
			repeat (2) @(posedge clk);
			rog.cfg_serial_clk <= 1'b0;
		end
		repeat (2) @(posedge clk);
		rog.cfg_load_enable_n <= 1'b1;
		rog.cfg_serial_data <= ~w[0];
		repeat (8) @(posedge clk);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk)
	begin
		tick <= ~tick;
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			bad_count++;
			complete_run();
		end
	end
	// ==========================================
	// Tests
	// ==========================================
	initial
	begin
		int m;
		logic [4:0] e;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		sent(6'h00);
		chk("test", 32'h0, {31'h0, tst});
		chk("run", 32'h1, {31'h0, run});
		for (int v = 0; v < 32; v++)
		begin
			av(1'b1, REG_CMD, {26'h0, v[4:0], 1'b0});
			sent({v[4:0], 1'b0});
			m = v[4] ? int'(v[3:0]) : -int'(v[3:0]);
			chk("word", m, m1);
			chk("shift", m * 18, sh);
		end
		// Second command stalls until the first frame has gone out
		av(1'b1, REG_CMD, 32'h0a);
		av(1'b1, REG_CMD, 32'h22);
		sent(6'h22);
		chk("stall", 32'h1, m1);
		av(1'b0, REG_CMD, 32'h0);
		chk("cmd rd", 32'h22, s);
		av(1'b1, REG_CMD, 32'h21);
		sent(6'h21);
		gain <= 1'b1;
		repeat (6) @(posedge clk);
		chk("test", 32'h2, {30'h0, tst, run});
		chk("div", 32'h1, {31'h0, div});
		gain <= 1'b0;
		repeat (6) @(posedge clk);
		chk("div low", 32'h0, {31'h0, div});
		av(1'b1, REG_ALIGN, 32'h1409);
		av(1'b1, REG_CMD, 32'h100);
		sent(6'h06);
		chk("centre", -3, m1);
		chk("test off", 32'h1, {30'h0, tst, run});
		// Tick is three flops late, so in normal mode it reads inverted
		chk("div vco", {31'h0, ~tick}, {31'h0, div});
		@(posedge clk);
		chk("div vco", {31'h0, ~tick}, {31'h0, div});
		av(1'b0, REG_ALIGN, 32'h0);
		chk("align rd", 32'h1409, s);
		av(1'b0, REG_CMD, 32'h0);
		chk("cmd rd", 32'h06, s);
		av(1'b1, REG_CODE, 32'h21);
		av(1'b0, REG_STATUS, 32'h0);
		chk("gcr bad", 32'h1, {31'h0, s[1]});
		av(1'b1, REG_CODE, 32'h11);
		av(1'b0, REG_STATUS, 32'h0);
		chk("gcr bad", 32'h1, {31'h0, s[1]});
		av(1'b1, REG_CODE, 32'h31);
		av(1'b0, REG_STATUS, 32'h0);
		chk("gcr ok", 32'h0, {31'h0, s[1]});
		av(1'b1, REG_CODE, 32'h94710002);
		av(1'b0, REG_STATUS, 32'h0);
		chk("freq bad", 32'h1, {31'h0, s[2]});
		chk("suggest", 32'h0, {29'h0, s[6:4]});
		av(1'b1, REG_CODE, 32'h94700012);
		av(1'b0, REG_STATUS, 32'h0);
		chk("freq ok", 32'h0, {31'h0, s[2]});
		av(1'b1, REG_CODE, 32'h4e200002);
		av(1'b0, REG_STATUS, 32'h0);
		chk("suggest", 32'h2, {29'h0, s[6:4]});
		av(1'b0, REG_CODE, 32'h0);
		chk("code rd", 32'h4e200002, s);
		for (int c = 0; c < 8; c++)
		begin
			rs <= c[2:0];
			repeat (8) @(posedge clk);
			e = c > 5 ? {RNG_1M25, 2'h2} : c == 5 ? {RNG_2M5, 2'h2} :
				c == 4 ? {RNG_5M, 2'h2} : c == 3 ? {RNG_10M, 2'h2} :
				c == 2 ? {RNG_20M, 2'h0} : {RNG_50M, 2'h1};
			chk("range", e, {rng, gcr, cap});
		end
		rg(6'h26, 1'b0);
		chk("load", 32'h3, m2);
		rg(6'h3e, 1'b1);
		chk("ignored", 32'h3, m2);
		// Empty frame commits the shifter, so stray pulses would show
		rog.cfg_load_enable_n <= 1'b0;
		repeat (4) @(posedge clk);
		rog.cfg_load_enable_n <= 1'b1;
		repeat (8) @(posedge clk);
		chk("ignored", 32'h3, m2);
		complete_run();
	end
endmodule
